/* inc/plsc_pkg.sv */
// Package of the PLL lock, status and clock control block.
// Assumes a 32-bit APB slave on pclk; bit 0 of each word is the LSB on the bus.
package plsc_pkg;

  // ==========================================================================
  // Register byte addresses.
  localparam logic [31:0] PLS_ADDR     = 32'h8007_FC54;
  localparam logic [31:0] CCR_ADDR     = 32'h8007_EC50;
  localparam logic [31:0] IRQ_ST_ADDR  = 32'h8007_FC58;
  localparam logic [31:0] IRQ_EN_ADDR  = 32'h8007_FC5C;
  localparam logic [31:0] IRQ_CLR_ADDR = 32'h8007_FC60;

  // ==========================================================================
  // Field positions in pll_lock_status (bus bit = 31 - printed bit).
  localparam int PLS_LOO_BIT    = 0;
  localparam int PLS_LIVE_BIT   = 1;
  localparam int PLS_STICKY_BIT = 2;
  localparam int PLS_WUR_BIT    = 8;
  localparam int PLS_TMS_LSB    = 16;
  localparam int PLS_DIVIDER_WRITE_LOCK_BIT   = 24;
  localparam int PLS_POWER_SELECT_WRITE_LOCK_BIT   = 25;
  localparam int PLS_MPL_BIT    = 26;
  localparam int PLS_TME_BIT    = 27;

  // Field positions in clock_control_reg.
  localparam int CCR_RFD_LSB = 0;
  localparam int CCR_LPM_LSB = 8;
  localparam int CCR_MF_LSB  = 19;

  // Interrupt status, enable and clear layout.
  localparam int IRQ_LOSS_BIT = 0;
  localparam int IRQ_OSC_BIT  = 1;
  localparam int IRQ_LOCK_BIT = 2;
  localparam int IRQ_W        = 3;

  // ==========================================================================
  // Reset values, multiply base and divider limits.
  localparam logic [3:0] CCR_MF_RST  = 4'h2;
  localparam logic [3:0] CCR_RFD_RST = 4'h3;
  localparam logic [1:0] TMS_RST     = 2'h0;
  localparam logic [3:0] MF_BASE     = 4'h4;
  localparam logic [3:0] RFD_MAX     = 4'hA;
  localparam logic [10:0] DIV_MAX    = 11'h400;
  localparam logic [10:0] DIV_ONE    = 11'h001;

  // Low power mode select codes.
  typedef enum logic [1:0] {
    LPM_NORMAL = 2'b00,
    LPM_SINGLE = 2'b01,
    LPM_DOZE   = 2'b10,
    LPM_SLEEP  = 2'b11
  } plsc_lpm_e;

  // ==========================================================================
  // Output prescaler ratio for a divider code.
  function automatic logic [10:0] plsc_div_ratio(input logic [3:0] code);
    if (code > RFD_MAX) begin
      plsc_div_ratio = DIV_MAX;
    end else begin
      plsc_div_ratio = DIV_ONE << code;
    end
  endfunction : plsc_div_ratio

endpackage : plsc_pkg

/* rtl/plsc_prescaler.sv */
// Output prescaler: a tick every 2^n pclk cycles, with the ratio in use.
// Assumes the divider code is a flop on pclk.
`timescale 1ns/1ps
module plsc_prescaler (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic [3:0]  div_code,
  output logic      [10:0] div_ratio,
  output logic             div_tick
);

  logic [10:0] cnt_q;
  logic [10:0] cnt_d;
  logic [10:0] ratio_q;
  logic [10:0] ratio_d;
  logic        tick_q;
  logic        tick_d;

  // ==========================================================================
  // A change of code mid-period restarts cleanly, since >= catches a count past the new end.
  always_comb begin
    ratio_d = plsc_pkg::plsc_div_ratio(div_code);
    tick_d  = (cnt_q >= ratio_d - plsc_pkg::DIV_ONE);
    cnt_d   = tick_d ? 11'h000 : cnt_q + plsc_pkg::DIV_ONE;
  end

  // Registers only.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q   <= 11'h000;
      ratio_q <= plsc_pkg::DIV_ONE;
      tick_q  <= 1'b0;
    end else begin
      cnt_q   <= cnt_d;
      ratio_q <= ratio_d;
      tick_q  <= tick_d;
    end
  end

  assign div_ratio = ratio_q;
  assign div_tick  = tick_q;

endmodule : plsc_prescaler

/* rtl/plsc_top.sv */
// PLL lock and status register, lock-protected clock control fields, interrupts.
// Assumes an APB3 master on pclk; presetn is the clock reset, keepalive_resetn
// the keep-alive supply power-on reset, sys_reset a synchronous other reset.
// Contract
// - Divider code 0..10 divides by 2^code; 11 and above divide by 1024.
// - Lock/status register cleared only by clock reset, kept over other resets; wake and sticky bits are cleared by keep-alive reset instead.
// - Test mode enable bit turns PLL test mode on when one.
// - Multiply lock bit set makes writes to multiply field ignored.
// - Power select lock bit set makes writes to low power select ignored.
// - Divider lock bit set makes writes to divider field ignored.
// - Test mode select 00 is normal; other codes are factory tests.
// - Wake-up request bit drives wake pin: zero low, one high.
// - Sticky lock flag set by software, cleared by any loss of lock; a loss while clock reset holds the lock filter low leaves it set.
// - Live lock flag reads the current PLL lock state.
// - Oscillator loss flag reads one when no crystal clock seen.
// - Multiply field low three bits give multiply by 4 through 11.
// - Low power select: normal, single chip, doze, sleep.
//
// The APB slave port was chosen for this implementation.
`timescale 1ns/1ps
module plsc_top (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        keepalive_resetn,
  input  wire logic        sys_reset,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        pll_locked,
  input  wire logic        osc_missing,
  output logic             power_wake_pin,
  output logic             test_mode_enable,
  output logic      [1:0]  test_mode_select,
  output logic      [3:0]  multiply_ratio,
  output logic      [1:0]  low_power_select,
  output logic      [10:0] div_ratio,
  output logic             div_tick,
  output logic             irq
);

  // ==========================================================================
  // Bus decode.
  logic wr_en;
  logic rd_setup;
  logic hit_pls;
  logic hit_ccr;
  logic hit_ist;
  logic hit_ien;
  logic hit_icl;
  logic hit_any;

  assign wr_en    = psel & penable & pwrite;
  assign rd_setup = psel & ~penable & ~pwrite;
  assign hit_pls  = (paddr == plsc_pkg::PLS_ADDR);
  assign hit_ccr  = (paddr == plsc_pkg::CCR_ADDR);
  assign hit_ist  = (paddr == plsc_pkg::IRQ_ST_ADDR);
  assign hit_ien  = (paddr == plsc_pkg::IRQ_EN_ADDR);
  assign hit_icl  = (paddr == plsc_pkg::IRQ_CLR_ADDR);
  assign hit_any  = hit_pls | hit_ccr | hit_ist | hit_ien | hit_icl;

  // Zero wait states; an unmapped address errors in the access phase.
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~hit_any;

  // ==========================================================================
  // Pin synchronisers: three stages, the filtered level moves when stages 2 and 3 agree.
  logic [2:0] lock_s_q;
  logic [2:0] osc_s_q;
  logic       lock_f_q;
  logic       lock_f_d;
  logic       osc_f_q;
  logic       osc_f_d;

  always_comb begin
    lock_f_d = (lock_s_q[2] == lock_s_q[1]) ? lock_s_q[1] : lock_f_q;
    osc_f_d  = (osc_s_q[2] == osc_s_q[1]) ? osc_s_q[1] : osc_f_q;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lock_s_q <= 3'h0;
      osc_s_q  <= 3'h0;
      lock_f_q <= 1'b0;
      osc_f_q  <= 1'b0;
    end else begin
      lock_s_q <= {lock_s_q[1:0], pll_locked};
      osc_s_q  <= {osc_s_q[1:0], osc_missing};
      lock_f_q <= lock_f_d;
      osc_f_q  <= osc_f_d;
    end
  end

  // ==========================================================================
  // Lock and status fields cleared by clock reset.
  logic       tme_q;
  logic       tme_d;
  logic       mpl_q;
  logic       mpl_d;
  logic       power_select_write_lock_q;
  logic       power_select_write_lock_d;
  logic       divider_write_lock_q;
  logic       divider_write_lock_d;
  logic [1:0] tms_q;
  logic [1:0] tms_d;
  logic       pls_wr;

  assign pls_wr = wr_en & hit_pls;

  // Only named fields are stored, so reserved bits drop writes.
  always_comb begin
    tme_d  = tme_q;
    mpl_d  = mpl_q;
    power_select_write_lock_d = power_select_write_lock_q;
    divider_write_lock_d = divider_write_lock_q;
    tms_d  = tms_q;
    if (pls_wr) begin
      tme_d  = pwdata[plsc_pkg::PLS_TME_BIT];
      mpl_d  = pwdata[plsc_pkg::PLS_MPL_BIT];
      power_select_write_lock_d = pwdata[plsc_pkg::PLS_POWER_SELECT_WRITE_LOCK_BIT];
      divider_write_lock_d = pwdata[plsc_pkg::PLS_DIVIDER_WRITE_LOCK_BIT];
      tms_d  = pwdata[plsc_pkg::PLS_TMS_LSB +: 2];
    end
  end

  // Only presetn reaches these flops; sys_reset deliberately does not.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tme_q  <= 1'b0;
      mpl_q  <= 1'b0;
      power_select_write_lock_q <= 1'b0;
      divider_write_lock_q <= 1'b0;
      tms_q  <= plsc_pkg::TMS_RST;
    end else begin
      tme_q  <= tme_d;
      mpl_q  <= mpl_d;
      power_select_write_lock_q <= power_select_write_lock_d;
      divider_write_lock_q <= divider_write_lock_d;
      tms_q  <= tms_d;
    end
  end

  // ==========================================================================
  // Keep-alive fields survive clock reset; of the resets, only the supply's own reset clears them.
  logic wur_q;
  logic wur_d;
  logic sticky_q;
  logic sticky_d;

  // A fall of the filtered lock clears the flag and beats a set; clock reset holds the filter low, so a level does not.
  always_comb begin
    wur_d    = pls_wr ? pwdata[plsc_pkg::PLS_WUR_BIT] : wur_q;
    sticky_d = (sticky_q | (pls_wr & pwdata[plsc_pkg::PLS_STICKY_BIT] & lock_f_q)) & ~(lock_f_q & ~lock_f_d);
  end

  always_ff @(posedge pclk or negedge keepalive_resetn) begin
    if (!keepalive_resetn) begin
      wur_q    <= 1'b0;
      sticky_q <= 1'b0;
    end else begin
      wur_q    <= wur_d;
      sticky_q <= sticky_d;
    end
  end

  // ==========================================================================
  // Clock control fields guarded by the write locks.
  logic [3:0]          mf_q;
  logic [3:0]          mf_d;
  logic [3:0]          rfd_q;
  logic [3:0]          rfd_d;
  plsc_pkg::plsc_lpm_e lpm_q;
  plsc_pkg::plsc_lpm_e lpm_d;
  logic [3:0]          mult_q;
  logic [3:0]          mult_d;
  logic                ccr_wr;

  assign ccr_wr = wr_en & hit_ccr;

  // Each field has its own lock, so a partly locked write updates the rest.
  always_comb begin
    mf_d   = mf_q;
    rfd_d  = rfd_q;
    lpm_d  = lpm_q;
    if (ccr_wr && !mpl_q) begin
      mf_d = pwdata[plsc_pkg::CCR_MF_LSB +: 4];
    end
    if (ccr_wr && !power_select_write_lock_q) begin
      lpm_d = plsc_pkg::plsc_lpm_e'(pwdata[plsc_pkg::CCR_LPM_LSB +: 2]);
    end
    if (ccr_wr && !divider_write_lock_q) begin
      rfd_d = pwdata[plsc_pkg::CCR_RFD_LSB +: 4];
    end
    mult_d = plsc_pkg::MF_BASE + {1'b0, mf_d[2:0]};
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mf_q   <= plsc_pkg::CCR_MF_RST;
      rfd_q  <= plsc_pkg::CCR_RFD_RST;
      lpm_q  <= plsc_pkg::LPM_NORMAL;
      mult_q <= plsc_pkg::MF_BASE + {1'b0, plsc_pkg::CCR_MF_RST[2:0]};
    end else begin
      mf_q   <= mf_d;
      rfd_q  <= rfd_d;
      lpm_q  <= lpm_d;
      mult_q <= mult_d;
    end
  end

  plsc_prescaler u_prescaler (
    .pclk      (pclk),
    .presetn   (presetn),
    .div_code  (rfd_q),
    .div_ratio (div_ratio),
    .div_tick  (div_tick)
  );

  // ==========================================================================
  // Interrupts: lock lost, oscillator lost, lock gained.
  logic                        lock_p_q;
  logic                        osc_p_q;
  logic [plsc_pkg::IRQ_W-1:0] ist_q;
  logic [plsc_pkg::IRQ_W-1:0] ist_d;
  logic [plsc_pkg::IRQ_W-1:0] ien_q;
  logic [plsc_pkg::IRQ_W-1:0] ien_d;
  logic [plsc_pkg::IRQ_W-1:0] evt;

  // A set in the clear cycle survives, since the event term is ORed after the clear; sys_reset still clears it.
  always_comb begin
    evt = '0;
    evt[plsc_pkg::IRQ_LOSS_BIT] = lock_p_q & ~lock_f_q;
    evt[plsc_pkg::IRQ_OSC_BIT]  = osc_f_q & ~osc_p_q;
    evt[plsc_pkg::IRQ_LOCK_BIT] = lock_f_q & ~lock_p_q;
    ist_d = ist_q;
    ien_d = ien_q;
    if (wr_en && hit_icl) begin
      ist_d = ist_q & ~pwdata[plsc_pkg::IRQ_W-1:0];
    end
    if (wr_en && hit_ien) begin
      ien_d = pwdata[plsc_pkg::IRQ_W-1:0];
    end
    ist_d = ist_d | evt;
    if (sys_reset) begin
      ist_d = '0;
      ien_d = '0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lock_p_q <= 1'b0;
      osc_p_q  <= 1'b0;
      ist_q    <= '0;
      ien_q    <= '0;
    end else begin
      lock_p_q <= lock_f_q;
      osc_p_q  <= osc_f_q;
      ist_q    <= ist_d;
      ien_q    <= ien_d;
    end
  end

  assign irq = |(ist_q & ien_q);

  // ==========================================================================
  // Read data is captured in the setup cycle and held through the access phase.
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;

  always_comb begin
    rdata_d = rdata_q;
    if (rd_setup) begin
      rdata_d = 32'h0000_0000;
      if (hit_pls) begin
        rdata_d[plsc_pkg::PLS_LOO_BIT]       = osc_f_q;
        rdata_d[plsc_pkg::PLS_LIVE_BIT]      = lock_f_q;
        rdata_d[plsc_pkg::PLS_STICKY_BIT]    = sticky_q;
        rdata_d[plsc_pkg::PLS_WUR_BIT]       = wur_q;
        rdata_d[plsc_pkg::PLS_TMS_LSB +: 2]  = tms_q;
        rdata_d[plsc_pkg::PLS_DIVIDER_WRITE_LOCK_BIT]      = divider_write_lock_q;
        rdata_d[plsc_pkg::PLS_POWER_SELECT_WRITE_LOCK_BIT]      = power_select_write_lock_q;
        rdata_d[plsc_pkg::PLS_MPL_BIT]       = mpl_q;
        rdata_d[plsc_pkg::PLS_TME_BIT]       = tme_q;
      end else if (hit_ccr) begin
        rdata_d[plsc_pkg::CCR_MF_LSB +: 4]  = mf_q;
        rdata_d[plsc_pkg::CCR_LPM_LSB +: 2] = lpm_q;
        rdata_d[plsc_pkg::CCR_RFD_LSB +: 4] = rfd_q;
      end else if (hit_ist) begin
        rdata_d[plsc_pkg::IRQ_W-1:0] = ist_q;
      end else if (hit_ien) begin
        rdata_d[plsc_pkg::IRQ_W-1:0] = ien_q;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_q <= 32'h0000_0000;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign prdata           = rdata_q;
  assign power_wake_pin   = wur_q;
  assign test_mode_enable = tme_q;
  assign test_mode_select = tms_q;
  assign multiply_ratio   = mult_q;
  assign low_power_select = lpm_q;

  // ==========================================================================
  // Checks.
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn || !keepalive_resetn);

  AST_DIV_RATIO: assert property ($stable(rfd_q) [*3] |-> div_ratio == plsc_pkg::plsc_div_ratio(rfd_q))
    else $error("Prescaler ratio does not match divider code.");
  AST_TME_WRITE: assert property (pls_wr |=> test_mode_enable == $past(pwdata[plsc_pkg::PLS_TME_BIT]))
    else $error("Test mode enable did not follow the write.");
  AST_MF_LOCK: assert property (ccr_wr && mpl_q |=> $stable(mf_q))
    else $error("Multiply field changed while locked.");
  AST_LPM_LOCK: assert property (ccr_wr && !power_select_write_lock_q |=> lpm_q == $past(pwdata[plsc_pkg::CCR_LPM_LSB +: 2]))
    else $error("Unlocked low power write was lost.");
  AST_RFD_LOCK: assert property (ccr_wr && divider_write_lock_q |=> $stable(rfd_q) ##2 $stable(div_ratio))
    else $error("Divider changed while locked.");
  AST_TMS_WRITE: assert property (pls_wr |=> test_mode_select == $past(pwdata[plsc_pkg::PLS_TMS_LSB +: 2]))
    else $error("Test mode select did not follow the write.");
  AST_WAKE_PIN: assert property (pls_wr && pwdata[plsc_pkg::PLS_WUR_BIT] |=> power_wake_pin)
    else $error("Wake pin not high after request.");
  AST_STICKY_LOSS: assert property (lock_f_q && !lock_f_d |=> !sticky_q)
    else $error("Sticky lock flag survived a loss of lock.");
  AST_LIVE_READ: assert property (rd_setup && hit_pls |=> prdata[plsc_pkg::PLS_LIVE_BIT] == $past(lock_f_q))
    else $error("Live lock flag misread.");
  AST_OSC_READ: assert property (rd_setup && hit_pls |=> prdata[plsc_pkg::PLS_LOO_BIT] == $past(osc_f_q))
    else $error("Oscillator loss flag misread.");
  AST_MF_RANGE: assert property (multiply_ratio >= 4'h4 && multiply_ratio <= 4'hB)
    else $error("Multiply ratio out of range.");
  AST_RSV_ZERO: assert property (rd_setup && hit_pls |=> (prdata & 32'hF0FC_FEF8) == 32'h0000_0000)
    else $error("Reserved bits read non-zero.");

  COV_LOCK_LOSS: cover property (sticky_q ##1 !sticky_q);
  COV_LOCKED_WRITE: cover property (ccr_wr && mpl_q && divider_write_lock_q);
  COV_IRQ: cover property (!irq ##1 irq);

endmodule : plsc_top

/* sim/plsc_pll_model.sv */
// Behavioural PLL and crystal detector that drive the lock status pins.
// Assumes pclk runs throughout; lock returns LOCK_CYC cycles after a loss.
`timescale 1ns/1ps
module plsc_pll_model #(
  parameter int LOCK_CYC = 20
) (
  input  wire logic pclk,
  input  wire logic resetn,
  input  wire logic drop_lock,
  input  wire logic stop_osc,
  output logic      pll_locked,
  output logic      osc_missing
);
  // ==========================================================================
  // Relock counter; a missing crystal also holds the loop out of lock.
  int cnt_q;
  always_ff @(posedge pclk or negedge resetn) begin
    if (!resetn) begin
      cnt_q <= 0;
    end else if (drop_lock || stop_osc) begin
      cnt_q <= 0;
    end else if (cnt_q < LOCK_CYC) begin
      cnt_q <= cnt_q + 1;
    end
  end
  assign pll_locked  = (cnt_q == LOCK_CYC);
  assign osc_missing = stop_osc;
endmodule : plsc_pll_model

/* sim/tb_plsc_top.sv */
// Self-checking bench of the PLL lock status block over APB.
// Assumes zero-wait APB slave; a PLL model drives the lock and crystal pins.
`timescale 1ns/1ps
module tb_plsc_top;
  // ==========================================================================
  // Signals and bench state.
  logic        pclk, presetn, keepalive_resetn, sys_reset, psel, penable, pwrite;
  logic [31:0] paddr, pwdata, prdata, v, cur, r;
  logic        pready, pslverr, pll_locked, osc_missing, power_wake_pin;
  logic        test_mode_enable, div_tick, irq, drop_lock, stop_osc;
  logic [1:0]  test_mode_select, low_power_select;
  logic [3:0]  multiply_ratio;
  logic [10:0] div_ratio;
  logic [31:0] lfsr = 32'd95652;
  logic [31:0] fm [3] = '{32'h0000_000F, 32'h0000_0300, 32'h0078_0000};
  logic [32:0] exp_q [$];
  int          fails = 0;
  int          num_checks = 0;
  int          cycles = 0;

  plsc_top dut (.pclk(pclk), .presetn(presetn), .keepalive_resetn(keepalive_resetn), .sys_reset(sys_reset),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pll_locked(pll_locked), .osc_missing(osc_missing),
    .power_wake_pin(power_wake_pin), .test_mode_enable(test_mode_enable), .test_mode_select(test_mode_select),
    .multiply_ratio(multiply_ratio), .low_power_select(low_power_select), .div_ratio(div_ratio),
    .div_tick(div_tick), .irq(irq));
  plsc_pll_model pll (.pclk(pclk), .resetn(keepalive_resetn), .drop_lock(drop_lock), .stop_osc(stop_osc),
    .pll_locked(pll_locked), .osc_missing(osc_missing));

  // ==========================================================================
  // Helpers: comparison, random source, APB master.
  task automatic check(input logic [32:0] seen, input logic [32:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  function automatic logic [31:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr;
  endfunction : rnd

  // Requests are held until pready is seen high; only the bench timeout ends the wait.
  task automatic apb(input logic [31:0] a, input logic w, input logic [31:0] d, input logic [32:0] e);
    if (!w) exp_q.push_back(e);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    apb(a, 1'b1, d, 33'h0_0000_0000);
  endtask : wr

  task automatic rd(input logic [31:0] a, input logic [32:0] e);
    apb(a, 1'b0, 32'h0000_0000, e);
  endtask : rd

  // Waits whole cycles, then lets the edge's updates settle.
  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
    #10;
  endtask : tick

  task automatic pulse_drop();
    @(posedge pclk);
    drop_lock <= 1'b1;
    @(posedge pclk);
    drop_lock <= 1'b0;
  endtask : pulse_drop

  task automatic test_done();
    $display("Checks %0d, mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : test_done

  // ==========================================================================
  // Clock, timeout and the read monitor that takes the oldest note.
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cycles++;
    if (psel && penable && pready && !pwrite) check({pslverr, prdata}, exp_q.pop_front());
    if (cycles == 20000) begin
      fails++;
      test_done();
    end
  end

  // ==========================================================================
  // Main sequence.
  initial begin
    {presetn, keepalive_resetn, sys_reset, psel, penable, pwrite, drop_lock, stop_osc} = '0;
    paddr = '0;
    pwdata = '0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    keepalive_resetn <= 1'b1;
    tick(30);
    check(multiply_ratio, 33'h6);
    check(div_ratio, 33'h8);
    rd(plsc_pkg::CCR_ADDR, 33'h0_0010_0003);
    rd(plsc_pkg::PLS_ADDR, 33'h0_0000_0002);
    $display("Test reset done");
    // Every divider, multiply and power code, with a random unused multiply bit.
    for (int c = 0; c < 16; c++) begin
      r = rnd();
      cur = (32'(r[0]) << 22) | (32'(c & 7) << 19) | (32'(c & 3) << 8) | 32'(c);
      wr(plsc_pkg::CCR_ADDR, cur);
      tick(4);
      check(div_ratio, (c > 10) ? 33'h400 : (33'h1 << c));
      if (c == 0) check(div_tick, 33'h1);
      check(multiply_ratio, 33'(4 + (c & 7)));
      check(low_power_select, 33'(c & 3));
      rd(plsc_pkg::CCR_ADDR, {1'b0, cur});
    end
    $display("Test codes done");
    // Each lock alone freezes its field while the other two still take writes.
    for (int k = 0; k < 3; k++) begin
      v = rnd() & 32'h0078_030F;
      wr(plsc_pkg::PLS_ADDR, 32'h0100_0000 << k);
      wr(plsc_pkg::CCR_ADDR, v);
      cur = (cur & fm[k]) | (v & ~fm[k]);
      rd(plsc_pkg::CCR_ADDR, {1'b0, cur});
    end
    $display("Test locks done");
    for (int t = 0; t < 4; t++) begin
      v = (32'(t) << 16) | (32'(t & 1) << 27) | (32'(t >> 1) << 8);
      wr(plsc_pkg::PLS_ADDR, v);
      tick(1);
      check(test_mode_select, 33'(t));
      check(test_mode_enable, 33'(t & 1));
      check(power_wake_pin, 33'(t >> 1));
      rd(plsc_pkg::PLS_ADDR, {1'b0, v | 32'h2});
    end
    v = rnd() | 32'h0000_0007;
    wr(plsc_pkg::PLS_ADDR, v);
    rd(plsc_pkg::PLS_ADDR, {1'b0, (v & 32'h0F03_0100) | 32'h6});
    rd(32'h8007_FC64, 33'h1_0000_0000);
    wr(plsc_pkg::PLS_ADDR, 32'h0000_0000);
    $display("Test fields done");
    // Loss of lock clears the sticky flag and raises the enabled interrupt.
    wr(plsc_pkg::IRQ_CLR_ADDR, 32'h7);
    wr(plsc_pkg::IRQ_EN_ADDR, 32'h1);
    tick(1);
    check(irq, 33'h0);
    pulse_drop();
    tick(6);
    check(irq, 33'h1);
    rd(plsc_pkg::PLS_ADDR, 33'h0);
    tick(30);
    rd(plsc_pkg::PLS_ADDR, 33'h2);
    rd(plsc_pkg::IRQ_ST_ADDR, 33'h5);
    wr(plsc_pkg::IRQ_EN_ADDR, 32'h0);
    tick(1);
    check(irq, 33'h0);
    wr(plsc_pkg::IRQ_EN_ADDR, 32'h3);
    wr(plsc_pkg::IRQ_CLR_ADDR, 32'h7);
    tick(1);
    check(irq, 33'h0);
    wr(plsc_pkg::PLS_ADDR, 32'h4);
    rd(plsc_pkg::PLS_ADDR, 33'h6);
    stop_osc <= 1'b1;
    tick(6);
    check(irq, 33'h1);
    rd(plsc_pkg::PLS_ADDR, 33'h1);
    stop_osc <= 1'b0;
    tick(30);
    rd(plsc_pkg::PLS_ADDR, 33'h2);
    $display("Test lock and interrupt done");
    // sys_reset keeps the register; clock reset keeps only wake and sticky.
    wr(plsc_pkg::PLS_ADDR, 32'h0803_0104);
    @(posedge pclk);
    sys_reset <= 1'b1;
    @(posedge pclk);
    sys_reset <= 1'b0;
    rd(plsc_pkg::PLS_ADDR, 33'h0803_0106);
    rd(plsc_pkg::IRQ_EN_ADDR, 33'h0);
    @(posedge pclk);
    presetn <= 1'b0;
    tick(2);
    check(power_wake_pin, 33'h1);
    check(test_mode_enable, 33'h0);
    presetn <= 1'b1;
    tick(6);
    check(multiply_ratio, 33'h6);
    rd(plsc_pkg::PLS_ADDR, 33'h106);
    $display("Test resets done");
    test_done();
  end
endmodule : tb_plsc_top
